// ---- acl_match_regs.svh ----
// Register offsets, field positions and constants of the access control entry matcher
`ifndef ACL_MATCH_REGS_SVH
`define ACL_MATCH_REGS_SVH

`define REG_CTRL 4'h0
`define REG_SPORT 4'h1
`define REG_DPORT 4'h2
`define REG_FLAGS 4'h3
`define REG_ETYPE 4'h4
`define REG_STATUS 4'h5
`define REG_COUNT 4'h6

// Control register fields
`define CTRL_SMODE_LO 0
`define CTRL_DMODE_LO 2
`define CTRL_ETYPE_BIT 4
`define CTRL_FTYPE_LO 5
`define CTRL_PROTO_LO 7

// Flag register: two bits per flag, FIN first
`define FLAG_FIELD_W 2

// Lowest accepted EtherType and codes refused for the specific criterion
`define ETYPE_MIN 16'h0600
`define ETYPE_IPV4 16'h0800
`define ETYPE_ARP 16'h0806
`define ETYPE_IPV6 16'h86DD

`define ZERO16 16'h0000
`define ZERO32 32'h0000_0000

`endif

// ---- acl_match_pkg.sv ----
// Types shared by the access control entry matcher
package acl_match_pkg;

	// Port criterion mode
	typedef enum logic [1:0] {
		port_any = 2'b00,
		port_exact = 2'b01,
		port_range = 2'b10
	} port_mode_type;

	// Three-state flag criterion
	typedef enum logic [1:0] {
		flag_any = 2'b00,
		flag_clear = 2'b01,
		flag_set = 2'b10
	} flag_mode_type;

	// Frame type selection of the entry
	typedef enum logic [1:0] {
		frame_any = 2'b00,
		frame_etype = 2'b01,
		frame_ip = 2'b10
	} frame_kind_type;

	// Layer-4 protocol selection of the entry
	typedef enum logic [1:0] {
		proto_any = 2'b00,
		proto_tcp = 2'b01,
		proto_udp = 2'b10
	} proto_kind_type;

	// Parsed header fields from the receive path
	typedef struct packed {
		logic valid;
		logic is_ip;
		logic is_tcp;
		logic is_udp;
		logic [5:0] tcp_flags;
		logic [15:0] src_port;
		logic [15:0] dst_port;
		logic [15:0] ether_type;
	} header_type;

	// Register bus request
	typedef struct packed {
		logic write;
		logic read;
		logic [3:0] addr;
		logic [31:0] wdata;
	} bus_req_type;

endpackage

// ---- port_criterion.sv ----
// One layer-4 port criterion: don't-care, exact value or inclusive range
`include "acl_match_regs.svh"

module port_criterion (
	input wire logic clk,
	input wire logic reset_n,
	input wire acl_match_pkg::port_mode_type mode,
	input wire logic [15:0] low,
	input wire logic [15:0] high,
	input wire logic [15:0] port,
	output logic hit
);
	import acl_match_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registered compare keeps the adder-free path short at 250 MHz
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit <= 1'b0;
		end else begin
			case (mode)
				port_any: hit <= 1'b1;
				port_exact: hit <= (port == low);
				port_range: hit <= (port >= low) && (port <= high);
				default: hit <= 1'b0;
			endcase
		end
	end

endmodule

// ---- acl_l4_ethertype_matcher.sv ----
// Access control entry matcher for layer-4 ports, TCP flags and EtherType
//
// Added by the designer: the strobed register port and the register addresses.
`include "acl_match_regs.svh"

module acl_l4_ethertype_matcher #(
	parameter int FLAG_COUNT = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire acl_match_pkg::bus_req_type bus_req,
	output logic [31:0] rdata,
	input wire acl_match_pkg::header_type header,
	output logic hit_valid,
	output logic hit,
	output logic etype_refused
);
	import acl_match_pkg::*;

	// Configuration registers
	port_mode_type src_mode;
	port_mode_type dst_mode;
	logic etype_specific;
	frame_kind_type frame_kind;
	proto_kind_type proto_kind;
	logic [15:0] src_low;
	logic [15:0] src_high;
	logic [15:0] dst_low;
	logic [15:0] dst_high;
	logic [2*FLAG_COUNT-1:0] flag_cfg;
	logic [15:0] etype_value;
	logic [31:0] hit_count;

	// First pipeline stage
	header_type stage;
	logic src_hit;
	logic dst_hit;
	logic [FLAG_COUNT-1:0] flag_ok;
	logic etype_ok;
	logic frame_ok;
	logic l4_applies;
	logic next_hit;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding used by both the write path and the refusal flag
	function automatic logic etype_legal(input logic [15:0] value);
		etype_legal = (value >= `ETYPE_MIN) && (value != `ETYPE_IPV4) &&
			(value != `ETYPE_ARP) && (value != `ETYPE_IPV6);
	endfunction

	function automatic port_mode_type port_mode_of(input logic [1:0] code);
		case (code)
			2'b01: port_mode_of = port_exact;
			2'b10: port_mode_of = port_range;
			default: port_mode_of = port_any;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Control register write; port modes outside the encoding fall back to don't-care
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			src_mode <= port_any;
			dst_mode <= port_any;
			etype_specific <= 1'b0;
			frame_kind <= frame_any;
			proto_kind <= proto_any;
		end else if (bus_req.write && bus_req.addr == `REG_CTRL) begin
			src_mode <= port_mode_of(bus_req.wdata[`CTRL_SMODE_LO +: 2]);
			dst_mode <= port_mode_of(bus_req.wdata[`CTRL_DMODE_LO +: 2]);
			etype_specific <= bus_req.wdata[`CTRL_ETYPE_BIT];
			frame_kind <= frame_kind_type'(bus_req.wdata[`CTRL_FTYPE_LO +: 2]);
			proto_kind <= proto_kind_type'(bus_req.wdata[`CTRL_PROTO_LO +: 2]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port bounds: low half holds the exact value or lower bound
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			src_low <= `ZERO16;
			src_high <= `ZERO16;
			dst_low <= `ZERO16;
			dst_high <= `ZERO16;
		end else if (bus_req.write) begin
			if (bus_req.addr == `REG_SPORT) begin
				src_low <= bus_req.wdata[15:0];
				src_high <= bus_req.wdata[31:16];
			end
			if (bus_req.addr == `REG_DPORT) begin
				dst_low <= bus_req.wdata[15:0];
				dst_high <= bus_req.wdata[31:16];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag criteria, two bits each
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_cfg <= '0;
		end else if (bus_req.write && bus_req.addr == `REG_FLAGS) begin
			flag_cfg <= bus_req.wdata[2*FLAG_COUNT-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// EtherType value: illegal codes are refused and the old value kept
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			etype_value <= `ZERO16;
			etype_refused <= 1'b0;
		end else if (bus_req.write && bus_req.addr == `REG_ETYPE) begin
			if (etype_legal(bus_req.wdata[15:0])) begin
				etype_value <= bus_req.wdata[15:0];
				etype_refused <= 1'b0;
			end else begin
				etype_refused <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port comparators
	// source port compare: don't-care, exact or range
	port_criterion src_cmp (
		.clk(clk),
		.reset_n(reset_n),
		.mode(src_mode),
		.low(src_low),
		.high(src_high),
		.port(header.src_port),
		.hit(src_hit)
	);

	port_criterion dst_cmp (
		.clk(clk),
		.reset_n(reset_n),
		.mode(dst_mode),
		.low(dst_low),
		.high(dst_high),
		.port(header.dst_port),
		.hit(dst_hit)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Header stage aligned with the comparators
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= '0;
		end else begin
			stage <= header;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag checks; flag order FIN, SYN, RST, PSH, ACK, URG from bit 0
	generate
		for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
			flag_mode_type fm;
			assign fm = flag_mode_type'(flag_cfg[`FLAG_FIELD_W*i +: `FLAG_FIELD_W]);
			// non-TCP frames fail a non-any flag
			always_comb begin
				case (fm)
					flag_clear: flag_ok[i] = stage.is_tcp && !stage.tcp_flags[i];
					flag_set: flag_ok[i] = stage.is_tcp && stage.tcp_flags[i];
					default: flag_ok[i] = 1'b1;
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Frame type, protocol and EtherType checks
	always_comb begin
		// EtherType only for the EtherType kind
		case (frame_kind)
			frame_etype: frame_ok = !stage.is_ip;
			frame_ip: frame_ok = stage.is_ip;
			default: frame_ok = 1'b1;
		endcase
		etype_ok = (frame_kind != frame_etype) || !etype_specific ||
			(stage.ether_type == etype_value);
		// layer-4 criteria need TCP or UDP
		case (proto_kind)
			proto_tcp: l4_applies = stage.is_tcp;
			proto_udp: l4_applies = stage.is_udp;
			default: l4_applies = 1'b1;
		endcase
		if (proto_kind == proto_any || frame_kind == frame_etype) begin
			// Layer-4 fields are ignored when no protocol is selected or the frame kind is EtherType
			next_hit = frame_ok && etype_ok;
		end else begin
			next_hit = frame_ok && etype_ok && l4_applies && src_hit && dst_hit && (&flag_ok);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result output, two cycles after the header
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_valid <= 1'b0;
			hit <= 1'b0;
		end else begin
			hit_valid <= stage.valid;
			hit <= stage.valid && next_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hit counter shows the entry's own activity to software
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_count <= `ZERO32;
		end else if (bus_req.write && bus_req.addr == `REG_COUNT) begin
			hit_count <= `ZERO32;
		end else if (hit_valid && hit) begin
			hit_count <= hit_count + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= `ZERO32;
		end else if (bus_req.read) begin
			case (bus_req.addr)
				`REG_CTRL: rdata <= {23'h0, proto_kind, frame_kind, etype_specific,
					dst_mode, src_mode};
				`REG_SPORT: rdata <= {src_high, src_low};
				`REG_DPORT: rdata <= {dst_high, dst_low};
				`REG_FLAGS: rdata <= {{(32-2*FLAG_COUNT){1'b0}}, flag_cfg};
				`REG_ETYPE: rdata <= {16'h0000, etype_value};
				`REG_STATUS: rdata <= {31'h0, etype_refused};
				`REG_COUNT: rdata <= hit_count;
				default: rdata <= `ZERO32;
			endcase
		end else begin
			rdata <= `ZERO32;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the matcher
	// inclusive range
	range_hit_a: assert property (@(posedge clk) disable iff (!reset_n)
		(src_mode == port_range && header.src_port >= src_low && header.src_port <= src_high
		&& $stable(src_mode)) |=> src_hit)
		else $error("source range miss inside bounds");
	exact_src_a: assert property (@(posedge clk) disable iff (!reset_n)
		(src_mode == port_exact && header.src_port != src_low && $stable(src_low)
		&& $stable(src_mode)) |=> !src_hit)
		else $error("source exact hit on wrong port");
	exact_dst_a: assert property (@(posedge clk) disable iff (!reset_n)
		(dst_mode == port_exact && header.dst_port == dst_low && $stable(dst_low)
		&& $stable(dst_mode)) |=> dst_hit)
		else $error("destination exact miss");
	any_src_a: assert property (@(posedge clk) disable iff (!reset_n)
		(src_mode == port_any && $stable(src_mode)) |=> src_hit)
		else $error("source don't-care missed");
	etype_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
		(bus_req.write && bus_req.addr == `REG_ETYPE && !etype_legal(bus_req.wdata[15:0]))
		|=> etype_refused && $stable(etype_value))
		else $error("illegal EtherType accepted");
	hit_valid_a: assert property (@(posedge clk) disable iff (!reset_n)
		hit |-> hit_valid)
		else $error("hit without valid");
	fin_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		(proto_kind == proto_tcp && frame_kind != frame_etype
		&& flag_cfg[1:0] == flag_clear && stage.valid && stage.tcp_flags[0]
		&& $stable(flag_cfg)) |=> !hit)
		else $error("FIN frame hit a FIN-clear entry");
	etype_miss_a: assert property (@(posedge clk) disable iff (!reset_n)
		(frame_kind == frame_etype && etype_specific && stage.ether_type != etype_value)
		|=> !hit)
		else $error("EtherType mismatch hit");
	// valid follows header by two cycles
	latency_a: assert property (@(posedge clk) disable iff (!reset_n)
		header.valid |-> ##2 hit_valid)
		else $error("result latency wrong");

	hit_seen_c: cover property (@(posedge clk) disable iff (!reset_n) hit);
	range_c: cover property (@(posedge clk) disable iff (!reset_n)
		hit && src_mode == port_range);
	refuse_c: cover property (@(posedge clk) disable iff (!reset_n) etype_refused);
	etype_c: cover property (@(posedge clk) disable iff (!reset_n)
		hit && frame_kind == frame_etype && etype_specific);

endmodule

// ---- hdr_source.sv ----
// Model of the receive path that hands parsed headers to the matcher
module hdr_source (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic go,
	input wire acl_match_pkg::header_type pattern,
	output acl_match_pkg::header_type header
);
	timeunit 1ns;
	timeprecision 100ps;
	import acl_match_pkg::*;
	header_type idle;

	// Fields flip between frames so stale values never look valid
	always_comb begin
		idle = ~header;
		idle.valid = 1'b0;
	end

	// One header a request, valid for one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			header <= '0;
		end else if (go) begin
			header <= pattern;
		end else begin
			header <= idle;
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the access control entry matcher
`include "acl_match_regs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import acl_match_pkg::*;
	logic clk;
	logic reset_n;
	bus_req_type bus_req;
	logic [31:0] rdata;
	header_type header;
	header_type pattern;
	logic go;
	logic hit_valid;
	logic hit;
	logic etype_refused;
	int bad_count;
	int cmp_count;

	acl_l4_ethertype_matcher DUT (
		.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
		.header(header), .hit_valid(hit_valid), .hit(hit),
		.etype_refused(etype_refused)
	);

	hdr_source src (.clk(clk), .reset_n(reset_n), .go(go), .pattern(pattern), .header(header));

	// 250 MHz clock
	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus_req <= '{1'b0, 1'b0, a, d};
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		bus_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk);
		bus_req.read <= 1'b0;
		#1;
		chk32(rdata, e);
	endtask

	// Result comes exactly two cycles after the header is taken
	task automatic frame(input logic tcp, input logic udp, input logic ip, input logic [5:0] fl,
		input logic [15:0] sp, input logic [15:0] dp, input logic [15:0] et, input logic exp);
		@(posedge clk);
		pattern <= '{1'b1, ip, tcp, udp, fl, sp, dp, et};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk1(hit_valid, 1'b1);
		chk1(hit, exp);
	endtask

	task automatic pf(input int s, input logic [15:0] p, input logic exp);
		frame(1'b1, 1'b0, 1'b1, 6'h00, s ? 16'h1234 : p, s ? p : 16'h1234, `ETYPE_IPV4, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(`REG_CTRL, 32'h0000_0000);
		rd(`REG_STATUS, 32'h0000_0000);
		rd(4'hF, 32'h0000_0000);
		frame(1'b1, 1'b0, 1'b1, 6'h3F, 16'h0007, 16'hBEEF, `ETYPE_IPV4, 1'b1);
		rd(`REG_COUNT, 32'h0000_0001);
		wr(`REG_COUNT, 32'h0000_0000);
		rd(`REG_COUNT, 32'h0000_0000);
		// Unused codes: port modes fall back to any, others stored as written
		wr(`REG_CTRL, 32'h0000_01FF);
		rd(`REG_CTRL, 32'h0000_01F0);
		frame(1'b1, 1'b0, 1'b1, 6'h3F, 16'h0007, 16'hBEEF, `ETYPE_IPV4, 1'b1);
	endtask

	// Exact and range on both port criteria, edges of the range
	task automatic t_ports;
		logic [3:0] a;
		for (int s = 0; s < 2; s++) begin
			a = s ? `REG_DPORT : `REG_SPORT;
			wr(`REG_CTRL, 32'h0000_0080 | (32'h1 << (2 * s)));
			wr(a, 32'h0000_FFFF);
			pf(s, 16'hFFFF, 1'b1);
			pf(s, 16'hFFFE, 1'b0);
			wr(a, 32'h0000_0000);
			pf(s, 16'h0000, 1'b1);
			wr(`REG_CTRL, 32'h0000_0080 | (32'h2 << (2 * s)));
			wr(a, 32'h0020_0010);
			rd(a, 32'h0020_0010);
			pf(s, 16'h0010, 1'b1);
			pf(s, 16'h0020, 1'b1);
			pf(s, 16'h000F, 1'b0);
			pf(s, 16'h0021, 1'b0);
		end
	endtask

	// Each flag must-set and must-clear, then UDP against flags and ports
	task automatic t_flags;
		logic [5:0] b;
		wr(`REG_CTRL, 32'h0000_00C0);
		frame(1'b1, 1'b0, 1'b0, 6'h00, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b0);
		for (int f = 0; f < 6; f++) begin
			b = 6'h01 << f;
			wr(`REG_FLAGS, 32'h0000_0002 << (2 * f));
			frame(1'b1, 1'b0, 1'b1, b, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b1);
			frame(1'b1, 1'b0, 1'b1, 6'h00, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b0);
			wr(`REG_FLAGS, 32'h0000_0001 << (2 * f));
			frame(1'b1, 1'b0, 1'b1, b, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b0);
			frame(1'b1, 1'b0, 1'b1, ~b, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b1);
		end
		wr(`REG_CTRL, 32'h0000_0104);
		wr(`REG_FLAGS, 32'h0000_0002);
		wr(`REG_DPORT, 32'h0000_0050);
		frame(1'b0, 1'b1, 1'b1, 6'h01, 16'h0001, 16'h0050, `ETYPE_IPV4, 1'b0);
		wr(`REG_FLAGS, 32'h0000_0000);
		frame(1'b0, 1'b1, 1'b1, 6'h01, 16'h0001, 16'h0050, `ETYPE_IPV4, 1'b1);
		frame(1'b0, 1'b1, 1'b1, 6'h00, 16'h0001, 16'h0051, `ETYPE_IPV4, 1'b0);
		frame(1'b1, 1'b0, 1'b1, 6'h00, 16'h0001, 16'h0050, `ETYPE_IPV4, 1'b0);
	endtask

	// Refused codes leave the stored value alone
	task automatic t_etype;
		logic [15:0] bad [4];
		bad = '{16'h05FF, `ETYPE_IPV4, `ETYPE_ARP, `ETYPE_IPV6};
		wr(`REG_CTRL, 32'h0000_0030);
		wr(`REG_ETYPE, 32'h0000_0600);
		rd(`REG_STATUS, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			wr(`REG_ETYPE, {16'h0000, bad[i]});
			rd(`REG_STATUS, 32'h0000_0001);
			chk1(etype_refused, 1'b1);
			rd(`REG_ETYPE, 32'h0000_0600);
		end
		frame(1'b0, 1'b0, 1'b0, 6'h00, 16'h0001, 16'h0002, 16'h0600, 1'b1);
		frame(1'b0, 1'b0, 1'b0, 6'h00, 16'h0001, 16'h0002, 16'h0601, 1'b0);
		frame(1'b0, 1'b0, 1'b1, 6'h00, 16'h0001, 16'h0002, 16'h0600, 1'b0);
		wr(`REG_ETYPE, 32'h0000_FFFF);
		#1;
		chk1(etype_refused, 1'b0);
		frame(1'b0, 1'b0, 1'b0, 6'h00, 16'h0001, 16'h0002, 16'hFFFF, 1'b1);
		wr(`REG_CTRL, 32'h0000_0020);
		frame(1'b0, 1'b0, 1'b0, 6'h00, 16'h0001, 16'h0002, 16'h1234, 1'b1);
		frame(1'b1, 1'b0, 1'b1, 6'h00, 16'h0001, 16'h0002, `ETYPE_IPV4, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		bus_req = '0;
		go = 1'b0;
		pattern = '0;
		bad_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_ports();
		t_flags();
		t_etype();
		complete_run();
	end

	// Bounded run length against a hang
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
